// file: verilog/slpctl_top.sv
// Sleep-mode clock controller: mode capture, domain gating, wake sequence
// How it works
// - Six software modes applied on sleep request
// - Idle stops core, converter and async timer; other peripherals keep clocks
// - Power-down stops all, waits interrupt or reset
// - Power-save keeps the asynchronous timer running
// - Noise-reduction keeps only oscillator, async timer and converter
// - Standby keeps only the main oscillator running
// - Extended standby keeps oscillator and async timer
`timescale 1ns/1ps
module slpctl_top (
    input wire logic sys_clk, // System clock, 200 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic clk_en, // Freezes all state while low
    input wire logic sleep_req, // Core sleep request, same clock
    input wire logic [2:0] mode_sel, // Requested sleep mode code
    input wire logic wake_irq, // Wake interrupt, asynchronous
    output logic [7:0] dom_en, // Per-domain clock enables
    output logic sleeping // High while any domain is held off
);

    slpctl_dom_if dbus ();
    slpctl_pkg::slpctl_state_t state;
    slpctl_pkg::slpctl_state_t next_state;
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic wake_meta;
    logic wake_s;
    logic [7:0] osc_run;
    logic [7:0] next_osc_run;

    ////////////////////////////////////////////////////////////////////////////
    // Wake line synchroniser; the first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wake_meta <= 1'b0;
            wake_s <= 1'b0;
        end
        else if (clk_en)
        begin
            wake_meta <= wake_irq;
            wake_s <= wake_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb
    begin
        next_state = state;
        next_mode = mode;
        next_cnt = cnt;
        case (state)
            slpctl_pkg::ST_RUN:
            begin
                if (sleep_req && slpctl_pkg::mode_ok(mode_sel))
                begin
                    next_mode = mode_sel;
                    next_state = slpctl_pkg::ST_SLEEP;
                end
            end
            slpctl_pkg::ST_SLEEP:
            begin
                if (wake_s)
                begin
                    // Stopped oscillator needs its restart time first
                    if ((slpctl_pkg::mode_mask(mode) & slpctl_pkg::MASK_OSC_ONLY) != 8'h00)
                        next_state = slpctl_pkg::ST_DOMS;
                    else
                    begin
                        next_state = slpctl_pkg::ST_OSC;
                        next_cnt = slpctl_pkg::OSC_START_LOAD;
                    end
                end
            end
            slpctl_pkg::ST_OSC:
            begin
                if (cnt == slpctl_pkg::CNT_ZERO)
                    next_state = slpctl_pkg::ST_DOMS;
                else
                    next_cnt = cnt - 8'h01;
            end
            slpctl_pkg::ST_DOMS:
            begin
                next_state = slpctl_pkg::ST_RUN;
            end
            default: next_state = slpctl_pkg::ST_RUN;
        endcase
    end

    // Decoder looks at the next state so enables line up with it
    assign dbus.state = next_state;
    assign dbus.mode = next_mode;

    slpctl_gate_dec u_dec (
        .bus (dbus.dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer registers; outputs come straight from flops
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= slpctl_pkg::ST_RUN;
            mode <= slpctl_pkg::RST_MODE;
            cnt <= slpctl_pkg::CNT_ZERO;
            dom_en <= slpctl_pkg::RST_DOM;
            sleeping <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            mode <= next_mode;
            cnt <= next_cnt;
            dom_en <= dbus.dom;
            sleeping <= (next_state != slpctl_pkg::ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Check helper: cycles spent waiting on the oscillator in this wake
    always_comb
    begin
        next_osc_run = 8'h00;
        if (state == slpctl_pkg::ST_OSC)
            next_osc_run = osc_run + 8'h01;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            osc_run <= 8'h00;
        else if (clk_en)
            osc_run <= next_osc_run;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_sleep_entry: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == slpctl_pkg::ST_RUN && sleep_req && slpctl_pkg::mode_ok(mode_sel)
        |=> sleeping && !dom_en[slpctl_pkg::DOM_CORE] && mode == $past(mode_sel))
        else $error("sleep request not applied");

    chk_idle_gates: assert property (
        @(posedge sys_clk) disable iff (rst)
        state == slpctl_pkg::ST_SLEEP && mode == slpctl_pkg::MODE_IDLE |-> dom_en == 8'h9e)
        else $error("idle mode gating wrong");

    chk_pdown_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        state == slpctl_pkg::ST_SLEEP && mode == slpctl_pkg::MODE_PDOWN && !wake_s
        |-> dom_en == 8'h00 ##1 state == slpctl_pkg::ST_SLEEP)
        else $error("power-down left without interrupt");

    chk_psave_gates: assert property (
        @(posedge sys_clk) disable iff (rst)
        state == slpctl_pkg::ST_SLEEP && mode == slpctl_pkg::MODE_PSAVE |-> dom_en == 8'h40)
        else $error("power-save gating wrong");

    chk_adcnr_gates: assert property (
        @(posedge sys_clk) disable iff (rst)
        state == slpctl_pkg::ST_SLEEP && mode == slpctl_pkg::MODE_ADC_NR |-> dom_en == 8'he0)
        else $error("noise-reduction gating wrong");

    chk_stby_gates: assert property (
        @(posedge sys_clk) disable iff (rst)
        state == slpctl_pkg::ST_SLEEP && mode == slpctl_pkg::MODE_STANDBY |-> dom_en == 8'h80)
        else $error("standby gating wrong");

    chk_xstby_gates: assert property (
        @(posedge sys_clk) disable iff (rst)
        state == slpctl_pkg::ST_SLEEP && mode == slpctl_pkg::MODE_EXT_STANDBY
        |-> dom_en == 8'hc0)
        else $error("extended standby gating wrong");

    chk_core_last: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(dom_en[slpctl_pkg::DOM_CORE]) && !$past(rst) |-> $past(dom_en) == 8'hfe)
        else $error("core resumed before domains restored");

    chk_osc_restart: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == slpctl_pkg::ST_SLEEP && wake_s && mode == slpctl_pkg::MODE_PDOWN
        |=> dom_en == 8'h80)
        else $error("oscillator not restarted first");

    chk_invalid_code: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == slpctl_pkg::ST_RUN && sleep_req
        && (mode_sel == 3'h4 || mode_sel == 3'h5) |=> !sleeping && dom_en == 8'hff)
        else $error("undefined mode code started a sleep");

    chk_freeze_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        !clk_en |=> $stable(dom_en) && $stable(sleeping))
        else $error("outputs moved while clock enable low");

    chk_idle_wake: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == slpctl_pkg::ST_SLEEP && wake_s && mode == slpctl_pkg::MODE_IDLE
        |=> dom_en == 8'hfe)
        else $error("idle wake waited on oscillator");

    chk_psave_restart: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == slpctl_pkg::ST_SLEEP && wake_s && mode == slpctl_pkg::MODE_PSAVE
        |=> dom_en == 8'hc0)
        else $error("power-save wake lost the async timer");

    chk_stby_wake: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == slpctl_pkg::ST_SLEEP && wake_s && mode == slpctl_pkg::MODE_STANDBY
        |=> dom_en == 8'hfe)
        else $error("standby wake not fast");

    chk_xstby_wake: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == slpctl_pkg::ST_SLEEP && wake_s
        && mode == slpctl_pkg::MODE_EXT_STANDBY |=> dom_en == 8'hfe)
        else $error("extended standby wake not fast");

    chk_osc_wait: assert property (
        @(posedge sys_clk) disable iff (rst)
        state == slpctl_pkg::ST_DOMS
        |-> osc_run == ((mode == slpctl_pkg::MODE_PDOWN || mode == slpctl_pkg::MODE_PSAVE)
        ? 8'(slpctl_pkg::OSC_START_CYC) : 8'h00))
        else $error("oscillator restart time wrong");

endmodule // slpctl_top

// file: verilog/slpctl_pkg.sv
// Constants, types and mode decoding for the sleep-mode clock controller
package slpctl_pkg;

    // Mode select codes presented by the core
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADC_NR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h6;
    localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

    // Bit positions of the domain enable vector
    localparam int DOM_CORE = 0;
    localparam int DOM_SRAM = 1;
    localparam int DOM_TIMER = 2;
    localparam int DOM_SPI = 3;
    localparam int DOM_IRQ = 4;
    localparam int DOM_ADC = 5;
    localparam int DOM_ATIMER = 6;
    localparam int DOM_OSC = 7;
    localparam int DOM_W = 8;

    // Domains left running in each sleep mode
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] MASK_NO_CORE = 8'hfe;
    // idle keeps oscillator, so timer, SPI and interrupt domains stay clocked
    localparam logic [7:0] MASK_IDLE = 8'h9e;
    localparam logic [7:0] MASK_ADC_NR = 8'he0;
    localparam logic [7:0] MASK_PDOWN = 8'h00;
    localparam logic [7:0] MASK_PSAVE = 8'h40;
    localparam logic [7:0] MASK_STANDBY = 8'h80;
    localparam logic [7:0] MASK_EXT_STANDBY = 8'hc0;
    localparam logic [7:0] MASK_OSC_ONLY = 8'h80;

    // Reset values
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [7:0] RST_DOM = 8'hff;

    // Oscillator restart time, rounded up to whole clock cycles
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OSC_START_NS = 1000;
    localparam int OSC_START_CYC = (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;
    localparam logic [7:0] OSC_START_LOAD = 8'(OSC_START_CYC - 1);
    localparam logic [7:0] CNT_ZERO = 8'h00;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OSC = 2'b10,
        ST_DOMS = 2'b11
    } slpctl_state_t;

    // Domains kept alive by a sleep mode; unknown codes keep all
    function automatic logic [7:0] mode_mask(input logic [2:0] mode);
        case (mode)
            MODE_IDLE: mode_mask = MASK_IDLE;
            MODE_ADC_NR: mode_mask = MASK_ADC_NR;
            MODE_PDOWN: mode_mask = MASK_PDOWN;
            MODE_PSAVE: mode_mask = MASK_PSAVE;
            MODE_STANDBY: mode_mask = MASK_STANDBY;
            MODE_EXT_STANDBY: mode_mask = MASK_EXT_STANDBY;
            default: mode_mask = MASK_ALL;
        endcase
    endfunction

    // Only the six documented codes may start a sleep
    function automatic logic mode_ok(input logic [2:0] mode);
        case (mode)
            MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE,
            MODE_STANDBY, MODE_EXT_STANDBY: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    endfunction

endpackage

// file: verilog/slpctl_dom_if.sv
// Carrier between the sleep sequencer and the domain gate decoder
`timescale 1ns/1ps
interface slpctl_dom_if;
    slpctl_pkg::slpctl_state_t state;
    logic [2:0] mode;
    logic [7:0] dom;

    modport ctl (output state, output mode, input dom);
    modport dec (input state, input mode, output dom);
endinterface

// file: verilog/slpctl_gate_dec.sv
// Domain enable decoder for the sleep sequencer state
`timescale 1ns/1ps
module slpctl_gate_dec (
    slpctl_dom_if.dec bus // State and mode in, enables out
);
    // Wake steps bring the oscillator back first, then every domain but the core
    always_comb
    begin
        case (bus.state)
            slpctl_pkg::ST_RUN: bus.dom = slpctl_pkg::MASK_ALL;
            slpctl_pkg::ST_SLEEP: bus.dom = slpctl_pkg::mode_mask(bus.mode);
            slpctl_pkg::ST_OSC: bus.dom = slpctl_pkg::mode_mask(bus.mode)
                | slpctl_pkg::MASK_OSC_ONLY;
            slpctl_pkg::ST_DOMS: bus.dom = slpctl_pkg::MASK_NO_CORE;
            default: bus.dom = slpctl_pkg::MASK_ALL;
        endcase
    end
endmodule // slpctl_gate_dec

// file: dv/slpctl_core_model.sv
// Behavioural core: waits a set time asleep, then holds its wake interrupt
`timescale 1ns/1ps
module slpctl_core_model (
    input wire logic sys_clk, // System clock
    input wire logic sleeping, // Controller busy flag
    input wire logic [7:0] delay, // Sleep cycles before waking
    output logic wake_irq // Wake request to controller
);
    logic [7:0] cnt;

    // Held until sleeping drops, so the synchroniser can never miss it
    always @(negedge sys_clk)
    begin
        if (sleeping !== 1'b1)
        begin
            cnt <= 8'h00;
            wake_irq <= 1'b0;
        end
        else if (cnt == delay)
            wake_irq <= 1'b1;
        else
            cnt <= cnt + 8'h01;
    end
endmodule // slpctl_core_model

// file: dv/sleep_mode_clock_gating_tb.sv
// Self-checking bench for the sleep-mode clock controller
`timescale 1ns/1ps
module sleep_mode_clock_gating_tb;
    logic sys_clk, rst, clk_en, sleep_req, wake_irq, sleeping;
    logic [2:0] mode_sel;
    logic [7:0] dom_en, dly, prev;
    int mismatches, checks_done;

    slpctl_top DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sleep_req(sleep_req),
        .mode_sel(mode_sel), .wake_irq(wake_irq), .dom_en(dom_en), .sleeping(sleeping));
    slpctl_core_model u_core (.sys_clk(sys_clk), .sleeping(sleeping), .delay(dly),
        .wake_irq(wake_irq));

    ////////////////////////////////////////////////////////////////////////////
    // Expected running domains per mode code
    function automatic logic [7:0] exp_mask(input logic [2:0] m);
        case (m)
            slpctl_pkg::MODE_IDLE: return slpctl_pkg::MASK_IDLE;
            slpctl_pkg::MODE_ADC_NR: return slpctl_pkg::MASK_ADC_NR;
            slpctl_pkg::MODE_PDOWN: return slpctl_pkg::MASK_PDOWN;
            slpctl_pkg::MODE_PSAVE: return slpctl_pkg::MASK_PSAVE;
            slpctl_pkg::MODE_STANDBY: return slpctl_pkg::MASK_STANDBY;
            slpctl_pkg::MODE_EXT_STANDBY: return slpctl_pkg::MASK_EXT_STANDBY;
            default: return 8'hff;
        endcase
    endfunction

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpn(input int got, input int exp);
        checks_done++;
        if (got != exp)
        begin
            mismatches++;
            $display("Error %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // One sleep and wake cycle; stray requests while asleep must be ignored
    task automatic run_mode(input logic [2:0] m, input logic [7:0] d);
        logic [7:0] e;
        int osc;
        e = exp_mask(m);
        osc = 0;
        @(negedge sys_clk);
        sleep_req = 1'b1;
        mode_sel = m;
        dly = d;
        @(negedge sys_clk);
        cmp8(dom_en, e);
        cmp8({7'h00, sleeping}, {7'h00, e !== 8'hff});
        prev = dom_en;
        for (int n = 0; n < 1000 && sleeping === 1'b1; n++)
        begin
            sleep_req = 1'($urandom);
            mode_sel = 3'($urandom);
            @(negedge sys_clk);
            if (wake_irq === 1'b0 && sleeping === 1'b1)
                cmp8(dom_en, e);
            if (dom_en === (e | 8'h80) && e[7] === 1'b0)
                osc++;
            if (dom_en[0] === 1'b1 && prev[0] === 1'b0)
                cmp8(prev, 8'hfe);
            prev = dom_en;
        end
        sleep_req = 1'b0;
        cmp8(dom_en, 8'hff);
        cmp8({7'h00, sleeping}, 8'h00);
        cmpn(osc, (e == 8'h00 || e == 8'h40) ? slpctl_pkg::OSC_START_CYC : 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 5 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Corner codes first (all eight, invalid ones too), then random ones
    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        sleep_req = 1'b0;
        mode_sel = 3'h0;
        dly = 8'h00;
        mismatches = 0;
        checks_done = 0;
        void'($urandom(32'h4240));
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        cmp8(dom_en, slpctl_pkg::RST_DOM);
        for (int i = 0; i < 8; i++)
            run_mode(3'(i), 8'(i));
        repeat (14)
            run_mode(3'($urandom), 8'($urandom % 40));
        // Clock enable low: a valid request must not be taken
        @(negedge sys_clk);
        clk_en = 1'b0;
        sleep_req = 1'b1;
        mode_sel = slpctl_pkg::MODE_STANDBY;
        repeat (3) @(negedge sys_clk);
        cmp8(dom_en, slpctl_pkg::MASK_ALL);
        cmp8({7'h00, sleeping}, 8'h00);
        clk_en = 1'b1;
        sleep_req = 1'b0;
        // Hardware reset also ends power-down, with no interrupt
        @(negedge sys_clk);
        sleep_req = 1'b1;
        mode_sel = slpctl_pkg::MODE_PDOWN;
        dly = 8'hff;
        @(negedge sys_clk);
        sleep_req = 1'b0;
        rst = 1'b1;
        cmp8(dom_en, slpctl_pkg::MASK_PDOWN);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        cmp8(dom_en, slpctl_pkg::RST_DOM);
        cmp8({7'h00, sleeping}, 8'h00);
        end_of_test();
    end

    // Watchdog: the full run needs far fewer cycles than this
    initial
    begin
        #100000;
        mismatches++;
        end_of_test();
    end
endmodule // sleep_mode_clock_gating_tb
